/* tocc_params.svh */
/*
  Constants of the timer output-compare channel: register offsets, field
  positions, reset values and trigger timing counts.
  Assumes it is included by bare name wherever these figures are needed.
*/
// Overview of operation
// - Mode and fast fields act only when direction is zero
// - Three-bit mode field in bits 14 to 12
// - Reference active high; polarity bit sets pin level
// - Mode 000 freezes output on match
// - Mode 001 sets reference on match
// - Mode 010 clears reference on match
// - Mode 011 toggles reference on match
// - Modes 100/101 force reference inactive/active
// - PWM1: active below compare up, inactive above down
// - PWM2 counting down: active above compare
// - PWM level changes on compare change or from frozen
// - Buffer off: compare write reaches shadow at once
// - Buffer on: buffer copied to shadow each update
// - Fast off: no activation before five cycles
// - Fast on: trigger edge acts as match, three cycles
// - Fast enable acts only in PWM modes
`ifndef TOCC_PARAMS_SVH
`define TOCC_PARAMS_SVH

// ==========================================================================
// Register map
`define TOCC_OFS_MODE 8'h00
`define TOCC_OFS_CMP 8'h04
`define TOCC_OFS_STATUS 8'h08

// ==========================================================================
// Mode register fields
`define TOCC_DIR_LSB 8
`define TOCC_DIR_MSB 9
`define TOCC_FAST_BIT 10
`define TOCC_BUF_BIT 11
`define TOCC_MODE_LSB 12
`define TOCC_MODE_MSB 14
`define TOCC_MODE_WMASK 32'h00007F00
`define TOCC_MODE_RST 32'h00000000

// ==========================================================================
// Compare value and status fields
`define TOCC_CMP_W 16
`define TOCC_CMP_RST 16'h0000
`define TOCC_STAT_REF_BIT 0
`define TOCC_STAT_PIN_BIT 1
`define TOCC_STAT_WARN_BIT 2
`define TOCC_STAT_SHADOW_LSB 16

// ==========================================================================
// Trigger timing, in clock cycles from the sampled trigger edge
`define TOCC_TRIG_FAST_CYCLES 3
`define TOCC_TRIG_NORMAL_CYCLES 5

`endif

/* tocc_pkg.sv */
/*
  Types and shared functions of the timer output-compare channel.
  Assumes tocc_params.svh is on the include path.
*/
`include "tocc_params.svh"

package tocc_pkg;

  // ========================================================================
  // Types
  typedef logic [`TOCC_CMP_W-1:0] tocc_cmp_t;

  typedef enum logic [2:0] {
    TOCC_FROZEN = 3'h0,
    TOCC_SET = 3'h1,
    TOCC_CLEAR = 3'h2,
    TOCC_TOGGLE = 3'h3,
    TOCC_FORCE_LOW = 3'h4,
    TOCC_FORCE_HIGH = 3'h5,
    TOCC_PWM1 = 3'h6,
    TOCC_PWM2 = 3'h7
  } tocc_mode_t;

  typedef enum logic [1:0] {
    TOCC_PH_IDLE = 2'b01,
    TOCC_PH_DATA = 2'b10
  } tocc_phase_t;

  // ========================================================================
  // Functions
  function automatic logic tocc_is_pwm(input tocc_mode_t m);
    return (m == TOCC_PWM1) || (m == TOCC_PWM2);
  endfunction : tocc_is_pwm

  function automatic logic tocc_pwm_level(input tocc_mode_t m, input logic down,
                                          input tocc_cmp_t cnt, input tocc_cmp_t ccr);
    logic lvl;
    lvl = down ? !(cnt > ccr) : (cnt < ccr);
    return (m == TOCC_PWM2) ? !lvl : lvl;
  endfunction : tocc_pwm_level

endpackage : tocc_pkg

/* tocc_link_if.sv */
/*
  Carrier between the channel core, its compare store and its trigger stage.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/10ps

interface tocc_link_if (
  input wire logic clk,
  input wire logic rst
);
  import tocc_pkg::*;

  logic cmp_wr;
  tocc_cmp_t cmp_wdata;
  logic buf_en;
  logic update_event;
  tocc_cmp_t cmp_rdata;
  tocc_cmp_t shadow;
  logic trig_in;
  logic fast_hit;
  logic hold;

  modport core (input clk, input rst, output cmp_wr, output cmp_wdata, output buf_en,
                output update_event, output trig_in, input cmp_rdata, input shadow,
                input fast_hit, input hold);
  modport store (input clk, input rst, input cmp_wr, input cmp_wdata, input buf_en,
                 input update_event, output cmp_rdata, output shadow);
  modport trig (input clk, input rst, input trig_in, output fast_hit, output hold);
endinterface : tocc_link_if

/* tocc_cmp_store.sv */
/*
  Compare value store: buffer register, active shadow register and the
  registered read-back word.
  Assumes the core raises cmp_wr for one cycle per software write.
*/
`timescale 1ns/10ps
`include "tocc_params.svh"

module tocc_cmp_store (
  tocc_link_if.store lnk
);
  import tocc_pkg::*;

  tocc_cmp_t preload;

  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      preload <= `TOCC_CMP_RST;
    end else if (lnk.cmp_wr) begin
      preload <= lnk.cmp_wdata;
    end
  end

  // A write landing with the update event goes straight through, not lost
  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      lnk.shadow <= `TOCC_CMP_RST;
    end else if (!lnk.buf_en && lnk.cmp_wr) begin
      lnk.shadow <= lnk.cmp_wdata;
    end else if (lnk.buf_en && lnk.update_event) begin
      lnk.shadow <= lnk.cmp_wr ? lnk.cmp_wdata : preload;
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      lnk.cmp_rdata <= `TOCC_CMP_RST;
    end else begin
      lnk.cmp_rdata <= lnk.buf_en ? preload : lnk.shadow;
    end
  end

  property p_direct_write;
    @(posedge lnk.clk) disable iff (lnk.rst)
      (!lnk.buf_en && lnk.cmp_wr) |=> (lnk.shadow == $past(lnk.cmp_wdata));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct write missed");

  property p_buffered_write;
    @(posedge lnk.clk) disable iff (lnk.rst)
      (lnk.buf_en && lnk.cmp_wr && !lnk.update_event) |=> $stable(lnk.shadow) ##1
      (lnk.cmp_rdata == $past(lnk.cmp_wdata, 2) || !$past(lnk.buf_en));
  endproperty
  a_buffered_write: assert property (p_buffered_write) else $error("buffer leaked");

endmodule : tocc_cmp_store

/* tocc_trig_edge.sv */
/*
  Trigger edge stage: detects rising trigger edges, times the fast path and
  the window in which normal compare activation is held back.
  Assumes trig_in is synchronous to the clock.
*/
`timescale 1ns/10ps
`include "tocc_params.svh"

module tocc_trig_edge (
  tocc_link_if.trig lnk
);
  import tocc_pkg::*;

  localparam int SR_W = `TOCC_TRIG_NORMAL_CYCLES - 2;

  logic trig_prev;
  logic [SR_W-1:0] stage;
  logic trig_edge;

  assign trig_edge = lnk.trig_in && !trig_prev;

  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      trig_prev <= 1'b0;
      stage <= '0;
    end else begin
      trig_prev <= lnk.trig_in;
      stage <= {stage[SR_W-2:0], trig_edge};
    end
  end

  // Hit two cycles after the edge so the registered pin moves in the third
  assign lnk.fast_hit = stage[`TOCC_TRIG_FAST_CYCLES-2];
  assign lnk.hold = trig_edge || (|stage);

  property p_fast_delay;
    @(posedge lnk.clk) disable iff (lnk.rst)
      trig_edge |-> !lnk.fast_hit ##1 !lnk.fast_hit ##1 lnk.fast_hit;
  endproperty
  a_fast_delay: assert property (p_fast_delay) else $error("fast hit mistimed");

  property p_hold_window;
    @(posedge lnk.clk) disable iff (lnk.rst)
      trig_edge |-> lnk.hold [*4];
  endproperty
  a_hold_window: assert property (p_hold_window) else $error("hold window short");

endmodule : tocc_trig_edge

/* tocc_channel.sv */
/*
  Output-compare channel of a general-purpose timer with an AHB-Lite slave
  for its mode, compare and status registers.
  Assumes the counter, update event, trigger and polarity come from the
  surrounding timer, synchronous to clk.
*/
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "tocc_params.svh"

module tocc_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire tocc_pkg::tocc_cmp_t counter_value,
  input wire logic count_down,
  input wire logic update_event,
  input wire logic trigger_in,
  input wire logic ch2_output_polarity,
  input wire logic one_pulse_select,
  output logic ch2_compare_reference,
  output logic ch2_output_pin
);
  import tocc_pkg::*;

  // ========================================================================
  // Sub-blocks
  tocc_link_if lnk (
    .clk(clk),
    .rst(rst)
  );

  tocc_cmp_store u_store (
    .lnk(lnk)
  );

  tocc_trig_edge u_trig (
    .lnk(lnk)
  );

  // ========================================================================
  // AHB-Lite slave
  tocc_phase_t phase;
  logic [7:0] dp_addr;
  logic dp_write;
  logic addr_take;
  logic wr_en;
  logic [31:0] mode_reg;
  logic [31:0] status_word;

  // Only whole-word transfers are issued; hsize is not needed for lanes
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_en = (phase == TOCC_PH_DATA) && dp_write;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= TOCC_PH_IDLE;
      dp_addr <= 8'h00;
      dp_write <= 1'b0;
    end else begin
      case (phase)
        TOCC_PH_IDLE, TOCC_PH_DATA: begin
          phase <= addr_take ? TOCC_PH_DATA : TOCC_PH_IDLE;
        end
        default: begin
          phase <= TOCC_PH_IDLE;
        end
      endcase
      if (addr_take) begin
        dp_addr <= haddr[7:0];
        dp_write <= hwrite;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `TOCC_MODE_RST;
    end else if (wr_en && dp_addr == `TOCC_OFS_MODE) begin
      mode_reg <= hwdata & `TOCC_MODE_WMASK;
    end
  end

  assign lnk.cmp_wr = wr_en && (dp_addr == `TOCC_OFS_CMP);
  assign lnk.cmp_wdata = hwdata[`TOCC_CMP_W-1:0];
  assign lnk.update_event = update_event;
  assign lnk.trig_in = trigger_in;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Unmapped offsets read as zero and ignore writes
  always_comb begin
    hrdata = 32'h00000000;
    if (phase == TOCC_PH_DATA && !dp_write) begin
      case (dp_addr)
        `TOCC_OFS_MODE: hrdata = mode_reg;
        `TOCC_OFS_CMP: hrdata = {16'h0000, lnk.cmp_rdata};
        `TOCC_OFS_STATUS: hrdata = status_word;
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // Field decode
  logic is_output;
  logic fast_en;
  tocc_mode_t eff_mode;
  logic pwm_on;
  logic fast_on;
  logic cfg_warn;

  assign is_output = (mode_reg[`TOCC_DIR_MSB:`TOCC_DIR_LSB] == 2'h0);
  assign eff_mode = is_output ? tocc_mode_t'(mode_reg[`TOCC_MODE_MSB:`TOCC_MODE_LSB])
                              : TOCC_FROZEN;
  assign fast_en = mode_reg[`TOCC_FAST_BIT];
  assign lnk.buf_en = mode_reg[`TOCC_BUF_BIT];
  assign pwm_on = tocc_is_pwm(eff_mode);
  assign fast_on = fast_en && pwm_on;
  // Flags an unbuffered PWM setup that software should not use
  assign cfg_warn = pwm_on && !lnk.buf_en && !one_pulse_select;

  assign status_word = {lnk.shadow, 13'h0000, cfg_warn, ch2_output_pin,
                        ch2_compare_reference};

  // ========================================================================
  // Compare reference
  logic match;
  logic pwm_level;
  logic prev_level;
  tocc_mode_t prev_mode;
  logic cmp_level;
  logic fast_event;
  logic blocked;
  logic next_ref;
  logic raw_ref;

  assign match = (counter_value == lnk.shadow);
  assign pwm_level = tocc_pwm_level(eff_mode, count_down, counter_value, lnk.shadow);
  // Level a compare match drives in each PWM mode
  assign cmp_level = (eff_mode == TOCC_PWM2);
  assign fast_event = fast_on && lnk.fast_hit;

  always_comb begin
    raw_ref = ch2_compare_reference;
    case (eff_mode)
      TOCC_SET: begin
        if (match) raw_ref = 1'b1;
      end
      TOCC_CLEAR: begin
        if (match) raw_ref = 1'b0;
      end
      TOCC_TOGGLE: begin
        if (match) raw_ref = !ch2_compare_reference;
      end
      TOCC_FORCE_LOW: begin
        raw_ref = 1'b0;
      end
      TOCC_FORCE_HIGH: begin
        raw_ref = 1'b1;
      end
      TOCC_PWM1, TOCC_PWM2: begin
        if (fast_event) begin
          raw_ref = cmp_level;
        end else if (pwm_level != prev_level || prev_mode == TOCC_FROZEN) begin
          raw_ref = pwm_level;
        end
      end
      default: begin
        raw_ref = ch2_compare_reference;
      end
    endcase
  end

  // Without the fast path a rise, other than forced active, is held off for the
  // trigger window; the PWM level is retried afterwards, a single match event is dropped
  assign blocked = lnk.hold && !fast_on && raw_ref && !ch2_compare_reference &&
                   (eff_mode != TOCC_FORCE_HIGH);
  assign next_ref = blocked ? ch2_compare_reference : raw_ref;

  always_ff @(posedge clk) begin
    if (rst) begin
      ch2_compare_reference <= 1'b0;
      ch2_output_pin <= 1'b0;
    end else begin
      ch2_compare_reference <= next_ref;
      ch2_output_pin <= next_ref ^ ch2_output_polarity;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_level <= 1'b0;
      prev_mode <= TOCC_FROZEN;
    end else begin
      if (!blocked) begin
        prev_level <= pwm_level;
      end
      prev_mode <= eff_mode;
    end
  end

  // ========================================================================
  // Checks
  property p_input_dir;
    @(posedge clk) disable iff (rst)
      !is_output |=> $stable(ch2_compare_reference);
  endproperty
  a_input_dir: assert property (p_input_dir) else $error("input channel moved ref");

  property p_mode_field;
    @(posedge clk) disable iff (rst)
      (is_output && mode_reg[14:12] == 3'h4) |=> !ch2_compare_reference;
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("mode field misplaced");

  property p_polarity;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> (ch2_output_pin == (ch2_compare_reference ^ $past(ch2_output_polarity)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

  property p_frozen;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_FROZEN) |=> (ch2_compare_reference == $past(ch2_compare_reference));
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen mode moved ref");

  property p_set_match;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_SET && match && !lnk.hold) |=> ch2_compare_reference;
  endproperty
  a_set_match: assert property (p_set_match) else $error("set on match failed");

  property p_clear_match;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_CLEAR && match) |=> !ch2_compare_reference;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("clear on match failed");

  property p_toggle_match;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_TOGGLE && match && !lnk.hold) |=>
      (ch2_compare_reference != $past(ch2_compare_reference));
  endproperty
  a_toggle_match: assert property (p_toggle_match) else $error("toggle failed");

  property p_force;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_FORCE_HIGH) |=> ch2_compare_reference ##0
      ($past(eff_mode) != TOCC_FORCE_LOW);
  endproperty
  a_force: assert property (p_force) else $error("force active failed");

  property p_pwm1_up;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_PWM1 && !count_down && counter_value < lnk.shadow &&
       !prev_level && !lnk.hold && !fast_event) |=> ch2_compare_reference;
  endproperty
  a_pwm1_up: assert property (p_pwm1_up) else $error("pwm1 not active");

  property p_pwm2_down;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_PWM2 && count_down && counter_value > lnk.shadow &&
       !prev_level && !lnk.hold && !fast_event) |=> ch2_compare_reference;
  endproperty
  a_pwm2_down: assert property (p_pwm2_down) else $error("pwm2 not active");

  property p_pwm_steady;
    @(posedge clk) disable iff (rst)
      (pwm_on && pwm_level == prev_level && prev_mode == eff_mode && !fast_event) |=>
      $stable(ch2_compare_reference);
  endproperty
  a_pwm_steady: assert property (p_pwm_steady) else $error("pwm ref moved");

  property p_hold_rise;
    @(posedge clk) disable iff (rst)
      (lnk.hold && !fast_on && !ch2_compare_reference && eff_mode != TOCC_FORCE_HIGH) |=>
      !ch2_compare_reference;
  endproperty
  a_hold_rise: assert property (p_hold_rise) else $error("early activation");

  property p_fast_match;
    @(posedge clk) disable iff (rst)
      fast_event |=> (ch2_compare_reference == $past(cmp_level));
  endproperty
  a_fast_match: assert property (p_fast_match) else $error("fast match missed");

  property p_fast_pwm_only;
    @(posedge clk) disable iff (rst)
      (fast_en && lnk.fast_hit && eff_mode == TOCC_SET && !match) |=>
      $stable(ch2_compare_reference);
  endproperty
  a_fast_pwm_only: assert property (p_fast_pwm_only) else $error("fast acted off pwm");

  // ========================================================================
  // Register and PWM level checks
  property p_read_idle;
    @(posedge clk) disable iff (rst)
      !(phase == TOCC_PH_DATA && !dp_write) |-> (hrdata == 32'h00000000);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read phase");

  property p_mode_mask;
    @(posedge clk) disable iff (rst)
      (mode_reg & ~`TOCC_MODE_WMASK) == 32'h00000000;
  endproperty
  a_mode_mask: assert property (p_mode_mask) else $error("reserved mode bit set");

  property p_mode_keep;
    @(posedge clk) disable iff (rst)
      (wr_en && dp_addr != `TOCC_OFS_MODE) |=> $stable(mode_reg);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode changed by other write");

  property p_pwm1_down;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_PWM1 && count_down && counter_value > lnk.shadow &&
       prev_level && !fast_event) |=> !ch2_compare_reference;
  endproperty
  a_pwm1_down: assert property (p_pwm1_down) else $error("pwm1 not inactive");

  property p_pwm2_up;
    @(posedge clk) disable iff (rst)
      (eff_mode == TOCC_PWM2 && !count_down && counter_value < lnk.shadow &&
       prev_level && !fast_event) |=> !ch2_compare_reference;
  endproperty
  a_pwm2_up: assert property (p_pwm2_up) else $error("pwm2 not inactive");

  property p_frozen_entry;
    @(posedge clk) disable iff (rst)
      (pwm_on && prev_mode == TOCC_FROZEN && !fast_event && !blocked) |=>
      (ch2_compare_reference == $past(pwm_level));
  endproperty
  a_frozen_entry: assert property (p_frozen_entry) else $error("pwm entry level wrong");

endmodule : tocc_channel

/* tb_timer_output_compare_channel.sv */
/*
  Self-checking bench for the timer output-compare channel: register access
  over AHB-Lite, the compare modes, PWM levels, compare buffering and the
  fast and normal trigger paths.
  Assumes the channel's design files and tocc_params.svh are compiled first.
*/
`timescale 1ns/10ps
`include "tocc_params.svh"

module tb_timer_output_compare_channel;
  import tocc_pkg::*;

  // ==========================================================================
  // Signals
  localparam int LIMIT = 3000;
  localparam logic [15:0] CMPV = 16'h0010;

  logic clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  tocc_cmp_t counter_value;
  logic count_down;
  logic update_event;
  logic trigger_in;
  logic ch2_output_polarity;
  logic one_pulse_select;
  logic ch2_compare_reference;
  logic ch2_output_pin;
  logic [31:0] rdv;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  tocc_mode_t tm [7] = '{TOCC_FORCE_HIGH, TOCC_FROZEN, TOCC_CLEAR, TOCC_SET, TOCC_FORCE_LOW,
                         TOCC_TOGGLE, TOCC_TOGGLE};
  bit tp [7] = '{0, 1, 1, 1, 0, 1, 1};
  bit te [7] = '{1, 1, 0, 1, 0, 1, 0};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  tocc_channel DUT (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .counter_value(counter_value),
    .count_down(count_down),
    .update_event(update_event),
    .trigger_in(trigger_in),
    .ch2_output_polarity(ch2_output_polarity),
    .one_pulse_select(one_pulse_select),
    .ch2_compare_reference(ch2_compare_reference),
    .ch2_output_pin(ch2_output_pin)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Checking and closing
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // A hang anywhere ends the run through the same report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      results();
    end
  end

  // ==========================================================================
  // Bus and stimulus tasks; each is entered and left just after a rising edge
  task ahb(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
    hsel <= 1'h1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge clk); while (hready !== 1'h1);
    rdv = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  task rdc(input string what, input logic [31:0] addr, input logic [31:0] exp);
    ahb(addr, 1'h0, 32'h0);
    check(what, rdv, exp);
  endtask : rdc

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task set_mode(input tocc_mode_t m, input logic b, input logic f, input logic [1:0] d);
    ahb(`TOCC_OFS_MODE, 1'h1, {17'h0, m, b, f, d, 8'h00});
  endtask : set_mode

  task pulse_match;
    counter_value <= CMPV;
    cyc(1);
    counter_value <= 16'h0000;
    cyc(3);
  endtask : pulse_match

  task pulse_update;
    update_event <= 1'h1;
    cyc(1);
    update_event <= 1'h0;
    cyc(1);
  endtask : pulse_update

  // Values read at an edge are those settled in the cycle before it
  task chk_out(input logic exp);
    check("reference", {31'h0, ch2_compare_reference}, {31'h0, exp});
    check("pin", {31'h0, ch2_output_pin}, {31'h0, exp ^ ch2_output_polarity});
  endtask : chk_out

  task hold_ref(input logic exp, input int k);
    repeat (k) begin
      @(posedge clk);
      check("reference held", {31'h0, ch2_compare_reference}, {31'h0, exp});
    end
  endtask : hold_ref

  task wait_ref(input logic exp, input int lim);
    int k;
    k = 1;
    @(posedge clk);
    while (ch2_compare_reference !== exp && k < lim) begin
      @(posedge clk);
      k++;
    end
    check("reference settled", {31'h0, ch2_compare_reference}, {31'h0, exp});
  endtask : wait_ref

  // ==========================================================================
  // Test sequence
  initial begin
    rst = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    counter_value = 16'h0000;
    count_down = 1'h0;
    update_event = 1'h0;
    trigger_in = 1'h0;
    ch2_output_polarity = 1'h0;
    one_pulse_select = 1'h0;
    repeat (2) @(posedge clk);
    chk_out(1'h0);
    rst <= 1'h0;
    cyc(1);
    rdc("mode reset", `TOCC_OFS_MODE, `TOCC_MODE_RST);
    rdc("compare reset", `TOCC_OFS_CMP, 32'h0);
    ahb(`TOCC_OFS_MODE, 1'h1, 32'hFFFFFFFF);
    rdc("mode fields", `TOCC_OFS_MODE, `TOCC_MODE_WMASK);
    rdc("unmapped", 32'h0000000C, 32'h0);
    // Immediate compare write, then buffered write and its update copy
    set_mode(TOCC_FROZEN, 1'h0, 1'h0, 2'h0);
    ahb(`TOCC_OFS_CMP, 1'h1, {16'h0, CMPV});
    rdc("shadow direct", `TOCC_OFS_STATUS, {CMPV, 16'h0});
    set_mode(TOCC_FROZEN, 1'h1, 1'h0, 2'h0);
    ahb(`TOCC_OFS_CMP, 1'h1, 32'h00000077);
    rdc("buffer read", `TOCC_OFS_CMP, 32'h00000077);
    rdc("shadow kept", `TOCC_OFS_STATUS, {CMPV, 16'h0});
    pulse_update();
    rdc("shadow updated", `TOCC_OFS_STATUS, 32'h00770000);
    ahb(`TOCC_OFS_CMP, 1'h1, {16'h0, CMPV});
    pulse_update();
    // Non-PWM modes, with the pin inverted
    ch2_output_polarity <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      set_mode(tm[i], 1'h0, 1'h0, 2'h0);
      if (tp[i]) begin
        pulse_match();
      end else begin
        cyc(3);
      end
      chk_out(te[i]);
    end
    set_mode(TOCC_SET, 1'h0, 1'h0, 2'h1);
    pulse_match();
    chk_out(1'h0);
    // PWM levels, buffered compare as software must use it
    set_mode(TOCC_FROZEN, 1'h1, 1'h0, 2'h0);
    counter_value <= 16'h0005;
    set_mode(TOCC_PWM1, 1'h1, 1'h0, 2'h0);
    cyc(2);
    chk_out(1'h1);
    counter_value <= 16'h0020;
    cyc(2);
    chk_out(1'h0);
    count_down <= 1'h1;
    counter_value <= CMPV;
    cyc(2);
    chk_out(1'h1);
    counter_value <= 16'h0020;
    cyc(2);
    chk_out(1'h0);
    set_mode(TOCC_FROZEN, 1'h1, 1'h0, 2'h0);
    set_mode(TOCC_PWM2, 1'h1, 1'h0, 2'h0);
    cyc(2);
    chk_out(1'h1);
    counter_value <= 16'h0008;
    cyc(2);
    chk_out(1'h0);
    // Entry from a forced mode keeps the level until the comparison moves
    set_mode(TOCC_FORCE_HIGH, 1'h1, 1'h0, 2'h0);
    count_down <= 1'h0;
    counter_value <= 16'h0020;
    set_mode(TOCC_PWM1, 1'h1, 1'h0, 2'h0);
    hold_ref(1'h1, 4);
    counter_value <= 16'h0005;
    cyc(2);
    counter_value <= 16'h0020;
    cyc(2);
    chk_out(1'h0);
    // Fast trigger path
    set_mode(TOCC_FROZEN, 1'h1, 1'h1, 2'h0);
    counter_value <= 16'h0005;
    set_mode(TOCC_PWM1, 1'h1, 1'h1, 2'h0);
    cyc(2);
    chk_out(1'h1);
    trigger_in <= 1'h1;
    wait_ref(1'h0, 4);
    trigger_in <= 1'h0;
    set_mode(TOCC_SET, 1'h1, 1'h1, 2'h0);
    trigger_in <= 1'h1;
    hold_ref(1'h0, 8);
    trigger_in <= 1'h0;
    // Second PWM mode counting up, then its fast match drives the active level
    set_mode(TOCC_FROZEN, 1'h1, 1'h1, 2'h0);
    set_mode(TOCC_PWM2, 1'h1, 1'h1, 2'h0);
    cyc(2);
    chk_out(1'h0);
    trigger_in <= 1'h1;
    wait_ref(1'h1, 4);
    trigger_in <= 1'h0;
    // Normal path: a rise right at the trigger edge is held back
    set_mode(TOCC_FROZEN, 1'h1, 1'h0, 2'h0);
    counter_value <= 16'h0020;
    set_mode(TOCC_PWM1, 1'h1, 1'h0, 2'h0);
    cyc(2);
    chk_out(1'h0);
    trigger_in <= 1'h1;
    counter_value <= 16'h0005;
    hold_ref(1'h0, 5);
    wait_ref(1'h1, 4);
    trigger_in <= 1'h0;
    // Unbuffered PWM is flagged unless one-pulse is selected
    set_mode(TOCC_PWM1, 1'h0, 1'h0, 2'h0);
    ahb(`TOCC_OFS_STATUS, 1'h0, 32'h0);
    check("warn set", {31'h0, rdv[`TOCC_STAT_WARN_BIT]}, 32'h1);
    one_pulse_select <= 1'h1;
    cyc(1);
    ahb(`TOCC_OFS_STATUS, 1'h0, 32'h0);
    check("warn clear", {31'h0, rdv[`TOCC_STAT_WARN_BIT]}, 32'h0);
    results();
  end

endmodule : tb_timer_output_compare_channel
